// file: design/hrs_pkg.sv
// constants, types and timing counts for the hub reset sequencer
package hrs_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam real RECOVERY_US = 500.0;
    localparam real STRAP_US = 1.5;
    localparam real CFG_LOAD_MS = 99.5;
    localparam real REQ_MS = 5.0;
    // longest times, so the counts round down
    localparam int RECOVERY_CYC = $rtoi(RECOVERY_US * CLK_HZ / 1.0e6);
    localparam int STRAP_CYC = $rtoi(STRAP_US * CLK_HZ / 1.0e6);
    localparam int CFG_LOAD_CYC = $rtoi(CFG_LOAD_MS * CLK_HZ / 1.0e3);
    localparam int REQ_CYC = $rtoi(REQ_MS * CLK_HZ / 1.0e3);
    localparam int CNT_W = 23;
    localparam int PORTS = 2;
    localparam int ADDR_W = 7;
    localparam int TEST_PINS = 16;
    localparam logic [ADDR_W-1:0] DEV_ADDR_RST = 7'h00;
    localparam logic [PORTS-1:0] PORT_RST = 2'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 23'h000000;

    typedef enum logic [1:0] {
        MODE_STRAP = 2'h0,
        MODE_EEPROM = 2'h1,
        MODE_SMBUS = 2'h2
    } hrs_mode_e;

    typedef enum logic [2:0] {
        ST_HOLD = 3'h0,
        ST_RECOVER = 3'h1,
        ST_LOAD = 3'h3,
        ST_APPLY = 3'h2,
        ST_ATTACHED = 3'h6,
        ST_TEST = 3'h7
    } hrs_state_e;
endpackage

// file: design/hrs_xnor_chain.sv
// continuity test XNOR chain with registered result
`timescale 1ns/1ns
module hrs_xnor_chain #(
    parameter int WIDTH = hrs_pkg::TEST_PINS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // chain
    input wire logic chain_en,
    input wire logic [WIDTH-1:0] chain_in,
    output logic chain_out
);
    import hrs_pkg::*;

    logic [WIDTH:0] link;

    assign link[0] = 1'b1;

    // each stage inverts on a toggle of its pin, so any single pin toggles the end
    for (genvar i = 0; i < WIDTH; i++) begin : g_stage
        assign link[i+1] = ~(link[i] ^ chain_in[i]);
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !chain_en) begin
            chain_out <= 1'b0;
        end else begin
            chain_out <= link[WIDTH];
        end
    end
endmodule

// file: design/hrs_reset_sequencer.sv
// hardware reset, configuration load and bus reset sequencing of the hub
`timescale 1ns/1ns
module hrs_reset_sequencer #(
    parameter int RECOVERY_CYC = hrs_pkg::RECOVERY_CYC,
    parameter int CFG_LOAD_CYC = hrs_pkg::CFG_LOAD_CYC,
    parameter int REQ_CYC = hrs_pkg::REQ_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // hardware reset pin and straps
    input wire logic hw_reset_n,
    input wire logic [1:0] cfg_sel,
    input wire logic test_pin,
    input wire logic sclk_in,
    input wire logic self_powered,
    // configuration load
    output logic eeprom_start,
    input wire logic eeprom_done,
    input wire logic smbus_done,
    output logic cfg_timeout,
    // upstream port
    input wire logic bus_reset,
    output logic attach,
    output logic phy_enable,
    input wire logic tx_req,
    output logic usb_pair_oe,
    input wire logic addr_set,
    input wire logic [hrs_pkg::ADDR_W-1:0] addr_val,
    output logic [hrs_pkg::ADDR_W-1:0] dev_addr,
    input wire logic cfg_set,
    input wire logic cfg_val,
    output logic configured,
    input wire logic suspend_req,
    input wire logic resume_req,
    output logic suspended,
    output logic tt_flush,
    output logic xact_abort,
    // host request watchdog
    input wire logic req_start,
    input wire logic req_done,
    output logic req_force_done,
    // downstream ports
    input wire logic [hrs_pkg::PORTS-1:0] port_power_req,
    input wire logic [hrs_pkg::PORTS-1:0] port_enable_req,
    input wire logic [hrs_pkg::PORTS-1:0] port_reset_req,
    output logic [hrs_pkg::PORTS-1:0] downstream_power_enable,
    output logic [hrs_pkg::PORTS-1:0] port_enable,
    output logic [hrs_pkg::PORTS-1:0] ds_port_reset,
    // green LED pins, also straps
    input wire logic [hrs_pkg::PORTS-1:0] led_in,
    output logic [hrs_pkg::PORTS-1:0] led_out,
    output logic [hrs_pkg::PORTS-1:0] led_oe,
    // status
    output logic osc_run,
    output logic pll_run,
    output logic operational,
    output logic test_mode,
    // continuity test
    input wire logic [hrs_pkg::TEST_PINS-1:0] test_pins,
    output logic chain_result_pin
);
    import hrs_pkg::*;

    hrs_state_e state_reg, state_next;
    hrs_mode_e mode_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] req_cnt_reg;
    logic req_active_reg;
    logic hw_prev_reg;
    logic [PORTS-1:0] strap_reg;
    logic clr, hw_release, entry_test, load_to, load_done, usb_reset;

    // pin treated as a level; the srst flop path keeps the release edge clean
    assign clr = srst | ~hw_reset_n;
    assign hw_release = hw_reset_n & ~hw_prev_reg;
    assign entry_test = test_pin & cfg_sel[1] & ~sclk_in;
    assign load_to = cnt_reg == CNT_W'(CFG_LOAD_CYC - 1);
    // bus reset only means something once attached
    assign usb_reset = bus_reset & (state_reg == ST_ATTACHED);
    // combinational so nothing runs one more cycle into the reset
    assign xact_abort = clr;
    assign test_mode = state_reg == ST_TEST;

    always_comb begin
        unique case (mode_reg)
            MODE_EEPROM: load_done = eeprom_done | load_to;
            // self-powered has no limit: wait for the host
            MODE_SMBUS: load_done = smbus_done | (~self_powered & load_to);
            default: load_done = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hw_prev_reg <= 1'b0;
        end else begin
            hw_prev_reg <= hw_reset_n;
        end
    end

    // oscillator then PLL restart after release
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            osc_run <= 1'b0;
            pll_run <= 1'b0;
        end else begin
            osc_run <= 1'b1;
            pll_run <= osc_run;
        end
    end

    // straps caught at the release edge, held through the hold window
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_reg <= MODE_STRAP;
            strap_reg <= PORT_RST;
        end else if (hw_release) begin
            mode_reg <= cfg_sel[1] ? MODE_SMBUS : (cfg_sel[0] ? MODE_EEPROM : MODE_STRAP);
            strap_reg <= led_in;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_HOLD: begin
                if (hw_release) begin
                    state_next = entry_test ? ST_TEST : ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (pll_run && cnt_reg == CNT_W'(RECOVERY_CYC - 1)) begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (load_done) begin
                    state_next = ST_APPLY;
                end
            end
            ST_APPLY: state_next = ST_ATTACHED;
            ST_ATTACHED: state_next = ST_ATTACHED;
            ST_TEST: state_next = ST_TEST;
            default: state_next = ST_HOLD;
        endcase
        if (clr) begin
            state_next = ST_HOLD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // interval counter only runs on a live PLL
    always_ff @(posedge sys_clk) begin
        if (clr || state_next != state_reg) begin
            cnt_reg <= CNT_RST;
        end else if (pll_run && (state_reg == ST_RECOVER || state_reg == ST_LOAD)) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            operational <= 1'b0;
            eeprom_start <= 1'b0;
            cfg_timeout <= 1'b0;
            attach <= 1'b0;
        end else begin
            operational <= operational | (state_next == ST_LOAD);
            eeprom_start <= state_reg == ST_RECOVER && state_next == ST_LOAD
                && mode_reg == MODE_EEPROM;
            if (state_reg == ST_LOAD && load_done && !eeprom_done && !smbus_done
                && mode_reg != MODE_STRAP) begin
                cfg_timeout <= 1'b1;
            end
            attach <= state_reg == ST_APPLY || state_reg == ST_ATTACHED;
        end
    end

    // transceivers come up only once attached, whatever configured says
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            phy_enable <= 1'b0;
            usb_pair_oe <= 1'b0;
        end else begin
            phy_enable <= state_reg == ST_ATTACHED;
            usb_pair_oe <= phy_enable & tx_req;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr || usb_reset) begin
            dev_addr <= DEV_ADDR_RST;
            configured <= 1'b0;
        end else begin
            if (addr_set) begin
                dev_addr <= addr_val;
            end
            if (cfg_set) begin
                configured <= cfg_val;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr || usb_reset) begin
            suspended <= 1'b0;
        end else if (suspend_req) begin
            suspended <= 1'b1;
        end else if (resume_req) begin
            suspended <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            tt_flush <= 1'b0;
        end else begin
            tt_flush <= usb_reset;
        end
    end

    // port power falls with configuration, so a bus reset drops it too
    always_ff @(posedge sys_clk) begin
        if (clr || usb_reset) begin
            downstream_power_enable <= PORT_RST;
            port_enable <= PORT_RST;
            ds_port_reset <= PORT_RST;
        end else begin
            downstream_power_enable <= port_power_req & {PORTS{configured}};
            port_enable <= port_enable_req & downstream_power_enable;
            // driven from the hub core only; upstream reset never reaches it
            ds_port_reset <= port_reset_req & downstream_power_enable;
        end
    end

    // request watchdog forces completion before the deadline
    always_ff @(posedge sys_clk) begin
        if (clr || usb_reset) begin
            req_active_reg <= 1'b0;
            req_cnt_reg <= CNT_RST;
            req_force_done <= 1'b0;
        end else begin
            req_force_done <= 1'b0;
            if (req_start) begin
                req_active_reg <= 1'b1;
                req_cnt_reg <= CNT_RST;
            end else if (req_done) begin
                req_active_reg <= 1'b0;
            end else if (req_active_reg) begin
                if (req_cnt_reg == CNT_W'(REQ_CYC - 2)) begin
                    req_force_done <= 1'b1;
                    req_active_reg <= 1'b0;
                end
                req_cnt_reg <= req_cnt_reg + CNT_W'(1);
            end
        end
    end

    // LED polarity follows the strap: strap high means active low
    for (genvar i = 0; i < PORTS; i++) begin : g_led
        always_ff @(posedge sys_clk) begin
            if (clr) begin
                led_oe[i] <= 1'b0;
                led_out[i] <= 1'b0;
            end else begin
                led_oe[i] <= pll_run;
                led_out[i] <= strap_reg[i] ^ (port_enable[i] & configured);
            end
        end
    end

    hrs_xnor_chain #(
        .WIDTH(TEST_PINS)
    ) u_chain (
        .sys_clk(sys_clk),
        .srst(clr),
        .chain_en(test_mode),
        .chain_in(test_pins),
        .chain_out(chain_result_pin)
    );

    localparam int STRAP_BOUND = STRAP_CYC;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_release;
        !hw_reset_n ##1 hw_reset_n;
    endsequence

    sequence s_leave_recover;
        state_reg == ST_RECOVER ##1 state_reg == ST_LOAD;
    endsequence

    sequence s_load_done;
        state_reg == ST_LOAD ##1 state_reg == ST_APPLY;
    endsequence

    a_ports_off_reset: assert property (!hw_reset_n |=> downstream_power_enable == PORT_RST
        && port_enable == PORT_RST) else $error("ports live in reset");
    a_pairs_hiz: assert property (!hw_reset_n |=> !usb_pair_oe && !phy_enable)
        else $error("pairs driven in reset");
    a_regs_default: assert property (!hw_reset_n ##1 !hw_reset_n |-> dev_addr == DEV_ADDR_RST
        && !configured && !suspended && !req_force_done)
        else $error("state kept in reset");
    a_osc_halted: assert property (!hw_reset_n |=> !osc_run && !pll_run)
        else $error("clock running in reset");
    a_led_disabled: assert property (!hw_reset_n |=> led_oe == PORT_RST)
        else $error("led driven in reset");
    a_recover_bound: assert property (state_reg == ST_RECOVER |-> cnt_reg < CNT_W'(RECOVERY_CYC))
        else $error("recovery too long");
    a_eeprom_start: assert property (s_leave_recover ##0 mode_reg == MODE_EEPROM |-> eeprom_start)
        else $error("eeprom read not started");
    a_strap_drive: assert property (s_release ##0 !entry_test |-> ##[1:STRAP_BOUND] &led_oe)
        else $error("outputs not driven in time");
    a_load_bound: assert property (state_reg == ST_LOAD && (mode_reg == MODE_EEPROM
        || !self_powered) |-> cnt_reg < CNT_W'(CFG_LOAD_CYC))
        else $error("config load too long");
    a_attach_after: assert property (s_load_done |=> attach && state_reg == ST_ATTACHED)
        else $error("no attach after load");
    a_req_bound: assert property (req_active_reg |-> req_cnt_reg < CNT_W'(REQ_CYC))
        else $error("request overran");
    a_bus_reset: assert property (usb_reset && hw_reset_n |=> dev_addr == DEV_ADDR_RST
        && !configured && downstream_power_enable == PORT_RST && tt_flush)
        else $error("bus reset incomplete");
    a_wake_reset: assert property (usb_reset && suspended && hw_reset_n |=> !suspended)
        else $error("still suspended");
    a_no_forward: assert property (usb_reset |=> ds_port_reset == PORT_RST)
        else $error("bus reset forwarded");
    a_test_entry: assert property (s_release ##0 entry_test |=> test_mode)
        else $error("test mode not entered");
endmodule

// file: dv/hrs_host_model.sv
// upstream host and board reset source facing the hub reset sequencer
`timescale 1ns/1ns
module hrs_host_model #(
    parameter int HOLD_CYC = 50,
    // host wait after attach, scaled down from the full figure
    parameter int WAIT_CYC = 20
) (
    // clock
    input wire logic sys_clk,
    // board reset pin
    output logic hw_reset_n,
    // upstream bus
    input wire logic attach,
    output logic bus_reset
);
    initial begin
        hw_reset_n = 1'b1;
        bus_reset = 1'b0;
    end

    // supplies are taken as settled, so only the low time matters
    task automatic hold_low();
        @(posedge sys_clk);
        hw_reset_n <= 1'b0;
        repeat (HOLD_CYC) @(posedge sys_clk);
    endtask

    task automatic release_pin();
        @(posedge sys_clk);
        hw_reset_n <= 1'b1;
    endtask

    // bounded wait for attach so a dead hub cannot hang the host
    task automatic bus_reset_seq(output bit ok);
        int n;
        n = 0;
        while (attach !== 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        ok = (attach === 1'b1);
        repeat (WAIT_CYC) @(posedge sys_clk);
        bus_reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        bus_reset <= 1'b0;
    endtask
endmodule

// file: dv/hrs_reset_sequencer_tb.sv
// self-checking bench for the hub reset sequencer
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin miscompares++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module hrs_reset_sequencer_tb;
    import hrs_pkg::*;
    localparam int RC = 40;
    localparam int CL = 60;
    localparam int RQ = 50;
    logic sys_clk, srst, hw_reset_n, test_pin, sclk_in, self_powered, eeprom_start;
    logic eeprom_done, smbus_done, cfg_timeout, bus_reset, attach, phy_enable, tx_req;
    logic usb_pair_oe, addr_set, cfg_set, cfg_val, configured, suspend_req, resume_req;
    logic suspended, tt_flush, xact_abort, req_start, req_done, req_force_done;
    logic osc_run, pll_run, operational, test_mode, chain_result_pin;
    logic [1:0] cfg_sel;
    logic [ADDR_W-1:0] addr_val, dev_addr;
    logic [PORTS-1:0] port_power_req, port_enable_req, port_reset_req, led_in, led_out;
    logic [PORTS-1:0] downstream_power_enable, port_enable, ds_port_reset, led_oe;
    logic [TEST_PINS-1:0] test_pins;
    int miscompares = 0;
    int n_compared = 0;
    int ee_cnt = 0;
    int tt_cnt = 0;
    int ds_cnt = 0;

    hrs_reset_sequencer #(.RECOVERY_CYC(RC), .CFG_LOAD_CYC(CL), .REQ_CYC(RQ))
        hrs_reset_sequencer_i (.sys_clk, .srst, .hw_reset_n, .cfg_sel, .test_pin, .sclk_in,
        .self_powered, .eeprom_start, .eeprom_done, .smbus_done, .cfg_timeout, .bus_reset,
        .attach, .phy_enable, .tx_req, .usb_pair_oe, .addr_set, .addr_val, .dev_addr,
        .cfg_set, .cfg_val, .configured, .suspend_req, .resume_req, .suspended, .tt_flush,
        .xact_abort, .req_start, .req_done, .req_force_done, .port_power_req,
        .port_enable_req, .port_reset_req, .downstream_power_enable, .port_enable,
        .ds_port_reset, .led_in, .led_out, .led_oe, .osc_run, .pll_run, .operational,
        .test_mode, .test_pins, .chain_result_pin);

    hrs_host_model #(.HOLD_CYC(50), .WAIT_CYC(20))
        hrs_host_model_i (.sys_clk, .hw_reset_n, .attach, .bus_reset);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // pulses are counted here so no one-cycle output slips between checks
    always @(posedge sys_clk) begin
        ee_cnt <= ee_cnt + (eeprom_start === 1'b1);
        tt_cnt <= tt_cnt + (tt_flush === 1'b1);
        ds_cnt <= ds_cnt + (ds_port_reset !== 2'h0);
    end

    task automatic print_verdict();
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wait_sig(input int sel, input int lim, output int n);
        logic s;
        n = 0;
        s = 1'b0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
            case (sel)
                0: s = operational;
                1: s = attach;
                2: s = req_force_done;
                default: s = eeprom_start;
            endcase
        end
    endtask

    // straps held across the release edge and after it
    task automatic boot(input logic [1:0] sel, input logic tp, input logic sp, input logic sc);
        hrs_host_model_i.hold_low();
        cfg_sel <= sel;
        {test_pin, self_powered, sclk_in} <= {tp, sp, sc};
        hrs_host_model_i.release_pin();
    endtask

    task automatic t_strap();
        int e0;
        e0 = ee_cnt;
        @(posedge sys_clk);
        led_in <= 2'h2;
        boot(2'h0, 1'b0, 1'b0, 1'b1);
        repeat (75) @(posedge sys_clk);
        #1;
        `CHK("led_inactive", 2'h3, led_oe)
        `CHK("led_strap", 2'h2, led_out)
        `CHK("no_read_strap", 0, ee_cnt - e0)
    endtask

    task automatic t_eeprom();
        int n;
        int e0;
        e0 = ee_cnt;
        boot(2'h1, 1'b0, 1'b0, 1'b1);
        repeat (5) @(posedge sys_clk);
        #1;
        `CHK("osc_pll", 2'h3, {osc_run, pll_run})
        `CHK("early_op", 1'b0, operational)
        wait_sig(3, RC + 10, n);
        `CHK("start_in_time", 1'b1, n <= RC + 5)
        `CHK("operational", 1'b1, operational)
        @(posedge sys_clk);
        eeprom_done <= 1'b1;
        @(posedge sys_clk);
        eeprom_done <= 1'b0;
        wait_sig(1, 10, n);
        `CHK("attach_after_load", 1'b1, n <= 5)
        `CHK("no_timeout", 1'b0, cfg_timeout)
        `CHK("one_start", 1, ee_cnt - e0)
    endtask

    task automatic t_bus_reset();
        int t0;
        int d0;
        bit ok;
        @(posedge sys_clk);
        {addr_set, cfg_set, cfg_val, suspend_req} <= 4'hF;
        addr_val <= 7'h2A;
        {port_power_req, port_enable_req, tx_req} <= 5'h1F;
        @(posedge sys_clk);
        {addr_set, cfg_set, suspend_req} <= 3'h0;
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK("addr", 7'h2A, dev_addr)
        `CHK("powered", 6'h3F, {configured, suspended, downstream_power_enable, port_enable})
        t0 = tt_cnt;
        d0 = ds_cnt;
        hrs_host_model_i.bus_reset_seq(ok);
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK("host_saw_attach", 1'b1, ok)
        `CHK("addr_zero", 7'h00, dev_addr)
        `CHK("unconfigured", 1'b0, configured)
        `CHK("power_off", 2'h0, downstream_power_enable)
        `CHK("tt_flushed", 1'b1, tt_cnt > t0)
        `CHK("awake", 1'b0, suspended)
        `CHK("not_forwarded", 0, ds_cnt - d0)
    endtask

    task automatic t_req();
        int n;
        @(posedge sys_clk);
        req_start <= 1'b1;
        @(posedge sys_clk);
        req_start <= 1'b0;
        wait_sig(2, RQ + 5, n);
        `CHK("forced_in_time", 1'b1, (n >= RQ - 2) && (n <= RQ + 1))
        @(posedge sys_clk);
        req_start <= 1'b1;
        @(posedge sys_clk);
        req_start <= 1'b0;
        repeat (10) @(posedge sys_clk);
        req_done <= 1'b1;
        @(posedge sys_clk);
        req_done <= 1'b0;
        wait_sig(2, RQ + 5, n);
        `CHK("done_not_forced", 1'b0, n <= RQ + 4)
    endtask

    task automatic t_hw();
        @(posedge sys_clk);
        {addr_set, cfg_set, cfg_val} <= 3'h7;
        @(posedge sys_clk);
        {addr_set, cfg_set} <= 2'h0;
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK("repowered", 9'h0AB, {dev_addr, downstream_power_enable})
        fork
            hrs_host_model_i.hold_low();
            begin
                repeat (4) @(posedge sys_clk);
                #1;
                `CHK("ports_off", 4'h0, {downstream_power_enable, port_enable})
                `CHK("phy_off", 2'h0, {phy_enable, usb_pair_oe})
                `CHK("abort", 1'b1, xact_abort)
                `CHK("defaults", 8'h00, {dev_addr, configured})
                `CHK("clocks_off", 2'h0, {osc_run, pll_run})
                `CHK("led_off", 2'h0, led_oe)
            end
        join
        hrs_host_model_i.release_pin();
        // let the led enable come up before the next hold cuts the boot short
        repeat (5) @(posedge sys_clk);
    endtask

    task automatic t_smbus();
        int n;
        int e0;
        e0 = ee_cnt;
        boot(2'h2, 1'b0, 1'b0, 1'b1);
        wait_sig(1, RC + CL + 20, n);
        `CHK("bus_pw_limit", 1'b1, n >= RC + CL - 5 && n <= RC + CL + 10)
        `CHK("timeout_flag", 1'b1, cfg_timeout)
        boot(2'h2, 1'b0, 1'b1, 1'b1);
        wait_sig(1, RC + CL + 20, n);
        `CHK("self_pw_waits", 1'b0, attach)
        @(posedge sys_clk);
        smbus_done <= 1'b1;
        @(posedge sys_clk);
        smbus_done <= 1'b0;
        wait_sig(1, 10, n);
        `CHK("attach_after_smbus", 1'b1, n <= 5)
        `CHK("no_read_smbus", 0, ee_cnt - e0)
    endtask

    task automatic t_xnor();
        boot(2'h2, 1'b1, 1'b0, 1'b1);
        repeat (5) @(posedge sys_clk);
        #1;
        `CHK("sclk_high_no_test", 1'b0, test_mode)
        boot(2'h2, 1'b1, 1'b0, 1'b0);
        repeat (5) @(posedge sys_clk);
        #1;
        `CHK("test_entry", 1'b1, test_mode)
        for (int k = 0; k < TEST_PINS; k++) begin
            @(posedge sys_clk);
            test_pins <= test_pins ^ ({{(TEST_PINS - 1){1'b0}}, 1'b1} << k);
            repeat (3) @(posedge sys_clk);
            #1;
            `CHK("chain", ~^test_pins, chain_result_pin)
        end
    endtask

    // generous span: every boot and wait together stay far below it
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        {srst, cfg_sel, test_pin, sclk_in, self_powered, eeprom_done, smbus_done} = 8'h88;
        {tx_req, addr_set, cfg_set, cfg_val, suspend_req, resume_req, req_start} = 7'h00;
        req_done = 1'b0;
        addr_val = 7'h00;
        {port_power_req, port_enable_req, port_reset_req, led_in} = 8'h00;
        test_pins = 16'h0000;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t_strap();
        t_eeprom();
        t_bus_reset();
        t_req();
        t_hw();
        t_smbus();
        t_xnor();
        print_verdict();
    end
endmodule
